// file: core/weekly_alarm_compare.sv
/*
  Weekly alarm compare: alarm registers, day mask, enable and flag,
  the delayed flag set and the open-drain interrupt pin.
  Assumes the timekeeping counters present the current time and a
  one-cycle pulse each time the minute changes, and that the serial
  engine delivers decoded register accesses.
*/
`timescale 1ns/100ps
module weekly_alarm_compare
(
  // Clock and power-on reset
  input  wire logic                        clock,
  input  wire logic                        sys_rst,
  // Time from the counters
  input  wire weekly_alarm_pkg::time_s     cur_time,
  input  wire logic                        minute_tick,
  // Decoded register access
  input  wire weekly_alarm_pkg::reg_req_s  reg_req,
  output logic [7:0]                       rd_data,
  // Hour format to the counters
  output logic                             hour_format_sel,
  // Interrupt pin, open-drain
  output logic                             alarm_b_irq_n,
  output logic                             alarm_b_irq_n_oe
);
  import weekly_alarm_pkg::*;

  // ****************************************************************
  // State
  // ****************************************************************
  // Settings, enable and flag, then the flag-delay machinery
  logic [6:0]  alarm_minute_r, alarm_minute_nxt;
  logic [5:0]  alarm_hour_r,   alarm_hour_nxt;
  logic [6:0]  day_mask_r,     day_mask_nxt;
  logic        enable_r,       enable_nxt;
  logic        format_r,       format_nxt;
  logic        flag_r,         flag_nxt;
  logic        pending_r,      pending_nxt;
  logic [11:0] delay_cnt_r,    delay_cnt_nxt;
  logic [7:0]  rd_data_r,      rd_data_nxt;
  logic        match;
  logic        delay_done;

  // Day mask bit selected by the weekday code; code 7 selects nothing
  function automatic logic day_selected(input logic [6:0] mask, input logic [2:0] code);
    day_selected = (code == 3'h7) ? 1'b0 : mask[code];
  endfunction

  // Match only on the minute transition, so a time equal at setup
  // waits for its next arrival and one minute raises one alarm
  assign match = enable_r && minute_tick
              && cur_time.minute == alarm_minute_r
              && cur_time.hour == alarm_hour_r
              && day_selected(day_mask_r, cur_time.weekday);

  // Last count reached; the flag sets on the following edge
  assign delay_done = pending_r && delay_cnt_r == FLAG_DELAY_LAST;

  // ****************************************************************
  // Register writes, delay and flag
  // ****************************************************************
  always_comb begin
    alarm_minute_nxt = alarm_minute_r;
    alarm_hour_nxt   = alarm_hour_r;
    day_mask_nxt     = day_mask_r;
    enable_nxt       = enable_r;
    format_nxt       = format_r;
    flag_nxt         = flag_r;
    pending_nxt      = pending_r;
    delay_cnt_nxt    = delay_cnt_r;
    // Host writes land on the edge that takes the strobe
    if (reg_req.wr) begin
      if (reg_req.addr == ADDR_HOURS) begin
        format_nxt = reg_req.data[HOUR_FORMAT_BIT];
      end else if (reg_req.addr == ADDR_ALARM_MINUTE) begin
        alarm_minute_nxt = reg_req.data[6:0];
      end else if (reg_req.addr == ADDR_ALARM_HOUR) begin
        alarm_hour_nxt = reg_req.data[5:0];
      end else if (reg_req.addr == ADDR_DAY_MASK) begin
        day_mask_nxt = reg_req.data[6:0];
      end else if (reg_req.addr == ADDR_CONTROL1) begin
        enable_nxt = reg_req.data[ENABLE_BIT];
      end else if (reg_req.addr == ADDR_CONTROL2) begin
        // Only a zero acts; a one is ignored
        if (!reg_req.data[FLAG_BIT]) begin
          flag_nxt = 1'b0;
        end
      end
    end
    // Delay counter runs from the match to the flag set
    if (match) begin
      pending_nxt   = 1'b1;
      delay_cnt_nxt = 12'h000;
    end else if (delay_done) begin
      pending_nxt   = 1'b0;
      delay_cnt_nxt = 12'h000;
    end else if (pending_r) begin
      delay_cnt_nxt = delay_cnt_r + 12'h001;
    end
    // Set wins over a clear in the same cycle; comparison keeps going
    if (delay_done && enable_r) begin
      flag_nxt = 1'b1;
    end
    // Disabling drops the flag and any alarm still in flight
    if (!enable_nxt) begin
      flag_nxt    = 1'b0;
      pending_nxt = 1'b0;
    end
  end

  // Power-on detection clears every setting and releases the pin
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      alarm_minute_r <= MINUTE_RST;
      alarm_hour_r   <= HOUR_RST;
      day_mask_r     <= MASK_RST;
      enable_r       <= 1'b0;
      format_r       <= 1'b0;
      flag_r         <= 1'b0;
      pending_r      <= 1'b0;
      delay_cnt_r    <= 12'h000;
    end else begin
      alarm_minute_r <= alarm_minute_nxt;
      alarm_hour_r   <= alarm_hour_nxt;
      day_mask_r     <= day_mask_nxt;
      enable_r       <= enable_nxt;
      format_r       <= format_nxt;
      flag_r         <= flag_nxt;
      pending_r      <= pending_nxt;
      delay_cnt_r    <= delay_cnt_nxt;
    end
  end

  // ****************************************************************
  // Read data
  // ****************************************************************
  // Unused and reserved bits read as zero
  always_comb begin
    rd_data_nxt = rd_data_r;
    if (reg_req.rd) begin
      if (reg_req.addr == ADDR_HOURS) begin
        rd_data_nxt = {format_r, 7'h00};
      end else if (reg_req.addr == ADDR_ALARM_MINUTE) begin
        rd_data_nxt = {1'b0, alarm_minute_r};
      end else if (reg_req.addr == ADDR_ALARM_HOUR) begin
        rd_data_nxt = {2'b00, alarm_hour_r};
      end else if (reg_req.addr == ADDR_DAY_MASK) begin
        rd_data_nxt = {1'b0, day_mask_r};
      end else if (reg_req.addr == ADDR_CONTROL1) begin
        rd_data_nxt = {enable_r, 7'h00};
      end else if (reg_req.addr == ADDR_CONTROL2) begin
        rd_data_nxt = {6'h00, flag_r & enable_r, 1'b0};
      end else begin
        rd_data_nxt = 8'h00;
      end
    end
  end

  // Read data registered so it stands until the next read
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      rd_data_r <= 8'h00;
    end else begin
      rd_data_r <= rd_data_nxt;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign rd_data          = rd_data_r;
  assign hour_format_sel  = format_r;
  // Pin only ever pulls low; the board pull-up makes the high level
  assign alarm_b_irq_n    = 1'b0;
  // Enable gates the pin as well, so disabling releases it at once
  assign alarm_b_irq_n_oe = flag_r & enable_r;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  // Checks stay off during power-on so the reset walk is not judged
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  no_irq_disabled_a: assert property (!enable_r |-> !alarm_b_irq_n_oe)
    else $error("interrupt pin driven while alarm disabled");
  match_starts_a: assert property (match |=> pending_r && delay_cnt_r == 12'h000)
    else $error("match did not start the flag delay");
  flag_timing_a: assert property ($rose(flag_r) |-> $past(delay_done))
    else $error("flag rose without the full delay");
  flag_disabled_a: assert property (!enable_r |-> !flag_r)
    else $error("flag set while disabled");
  flag_holds_a: assert property (flag_r && enable_nxt && !(reg_req.wr && reg_req.addr == ADDR_CONTROL2
                                 && !reg_req.data[FLAG_BIT]) |=> flag_r)
    else $error("flag dropped without a clear");
  flag_clear_a: assert property (reg_req.wr && reg_req.addr == ADDR_CONTROL2 && !reg_req.data[FLAG_BIT]
                                 && !delay_done |=> !flag_r && !alarm_b_irq_n_oe)
    else $error("writing zero did not clear the flag");
  pin_follows_a: assert property (alarm_b_irq_n_oe == (flag_r && enable_r) && !alarm_b_irq_n)
    else $error("interrupt pin does not follow the flag");
  masked_day_a: assert property (minute_tick && !day_selected(day_mask_r, cur_time.weekday)
                                 |=> !(pending_r && delay_cnt_r == 12'h000))
    else $error("alarm started on a masked day");
  tick_only_a: assert property (!minute_tick |-> !match)
    else $error("match outside a minute transition");
  delay_bound_a: assert property (pending_r |-> delay_cnt_r <= FLAG_DELAY_LAST)
    else $error("flag delay counter overran");

  // Enable, format and read-back checks
  enable_off_a: assert property (reg_req.wr && reg_req.addr == ADDR_CONTROL1 && !reg_req.data[ENABLE_BIT]
                                 |=> !pending_r && !flag_r)
    else $error("disable left an alarm in flight");
  idle_disabled_a: assert property (!enable_r |-> !pending_r)
    else $error("flag delay running while disabled");
  format_wr_a: assert property (reg_req.wr && reg_req.addr == ADDR_HOURS
                                |=> hour_format_sel == $past(reg_req.data[HOUR_FORMAT_BIT]))
    else $error("hour format write not taken");
  flag_read_a: assert property (reg_req.rd && reg_req.addr == ADDR_CONTROL2
                                |=> rd_data == {6'h00, $past(flag_r), 1'b0})
    else $error("flag read back wrong");

  // Main scenarios the bench is expected to reach
  alarm_fires_c: cover property (match ##1 pending_r [*8]);
  flag_set_c: cover property ($rose(flag_r));
  clear_again_c: cover property ($fell(flag_r) && enable_r);
  masked_tick_c: cover property (minute_tick && enable_r && !match);
  sticky_one_c: cover property (flag_r && reg_req.wr && reg_req.addr == ADDR_CONTROL2 && reg_req.data[FLAG_BIT]);

endmodule  // weekly_alarm_compare

// file: core/weekly_alarm_pkg.sv
/*
  Constants and carrier types for the weekly alarm compare block.
  Assumes a 40 MHz clock and a serial front end that hands over
  decoded register writes and reads as single-cycle strobes.
*/
// What this block does
// - Enable low: no comparison, no interrupt
// - Enable high: compare day, hour, minute; interrupt
// - Flag sets about 61 us after match
// - Flag only sets when enabled; reads 0 otherwise
// - Flag holds until software writes zero or clears enable
// - Writing 0 clears flag, releases pin
// - After clear, alarm repeats next occurrence
// - Clearing enable stops later alarms
// - Format bit: 0 twelve hour, 1 twenty-four
// - Hour codes per mode; bit 5 PM
// - Weekday code indexes the day mask bit
// - Masked-off weekdays never raise the alarm
// - Several day bits may be set together
// - Alarm hour bit 5: tens or PM
// - Equal time at setup fires next time
// - Power-on clears settings, flag, releases pin
package weekly_alarm_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [3:0] ADDR_HOURS        = 4'h2;
  localparam logic [3:0] ADDR_ALARM_MINUTE = 4'h8;
  localparam logic [3:0] ADDR_ALARM_HOUR   = 4'h9;
  localparam logic [3:0] ADDR_DAY_MASK     = 4'ha;
  localparam logic [3:0] ADDR_CONTROL1     = 4'he;
  localparam logic [3:0] ADDR_CONTROL2     = 4'hf;

  // Field positions
  localparam int HOUR_FORMAT_BIT  = 7;
  localparam int ENABLE_BIT       = 7;
  localparam int FLAG_BIT         = 1;

  // Reset values
  localparam logic [6:0] MINUTE_RST = 7'h00;
  localparam logic [5:0] HOUR_RST   = 6'h00;
  localparam logic [6:0] MASK_RST   = 7'h00;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLOCK_PERIOD_PS = 25000;
  localparam int FLAG_DELAY_PS   = 61000000;
  localparam int FLAG_DELAY_CYC  = (FLAG_DELAY_PS / CLOCK_PERIOD_PS < 1) ? 1 :
                                   FLAG_DELAY_PS / CLOCK_PERIOD_PS;
  localparam logic [11:0] FLAG_DELAY_LAST = 12'(FLAG_DELAY_CYC - 1);

  // ****************************************************************
  // Carriers
  // ****************************************************************
  typedef struct packed {
    logic [2:0] weekday;
    logic [5:0] hour;
    logic [6:0] minute;
  } time_s;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [3:0] addr;
    logic [7:0] data;
  } reg_req_s;

endpackage

// file: testbench/reg_host.sv
/*
  Host model: issues decoded register writes and reads to the alarm block.
  Assumes the block takes a strobe on the rising edge and answers the read
  one cycle later.
*/
`timescale 1ns/100ps
module reg_host
(
  // Clock
  input  wire logic                 clock,
  // Register access
  output weekly_alarm_pkg::reg_req_s reg_req,
  input  wire logic [7:0]           rd_data
);
  import weekly_alarm_pkg::*;

  initial reg_req = '0;

  // Idle bus shows inverted leftovers so stale data is never trusted
  task automatic idle(input logic [3:0] a, input logic [7:0] d);
    reg_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, data: ~d};
  endtask

  // One-cycle write strobe, launched at a falling edge
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(negedge clock);
    reg_req = '{wr: 1'b1, rd: 1'b0, addr: a, data: d};
    @(negedge clock);
    idle(a, d);
  endtask

  // One-cycle read strobe; data taken once the answer has landed
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(negedge clock);
    reg_req = '{wr: 1'b0, rd: 1'b1, addr: a, data: 8'h00};
    @(negedge clock);
    d = rd_data;
    idle(a, 8'h00);
  endtask
endmodule // reg_host

// file: testbench/tb.sv
/*
  Self-checking bench for the weekly alarm compare block.
  Assumes the host model drives the register strobes; the bench drives time.
*/
`timescale 1ns/100ps
module tb;
  import weekly_alarm_pkg::*;
  logic       clock = 1'b0;
  logic       sys_rst = 1'b1;
  time_s      cur_time = '0;
  logic       minute_tick = 1'b0;
  reg_req_s   reg_req;
  logic [7:0] rd_data, rv;
  logic       hour_format_sel, irq_o, irq_oe;
  int         fail_count = 0;
  int         compares = 0;

  always #12.5 clock = ~clock;

  weekly_alarm_compare i_dut (.clock(clock), .sys_rst(sys_rst), .cur_time(cur_time),
    .minute_tick(minute_tick), .reg_req(reg_req), .rd_data(rd_data),
    .hour_format_sel(hour_format_sel), .alarm_b_irq_n(irq_o), .alarm_b_irq_n_oe(irq_oe));
  reg_host i_host (.clock(clock), .reg_req(reg_req), .rd_data(rd_data));

  // ****************************************************************
  // Helpers
  // ****************************************************************
  task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // New minute arrives; waits past the flag delay, pin must stay off early
  task automatic tick(input logic [2:0] wd, input logic [5:0] hr);
    @(negedge clock);
    cur_time = {wd, hr, 7'h59};
    minute_tick = 1'b1;
    @(negedge clock);
    minute_tick = 1'b0;
    repeat (2438) @(negedge clock);
    chk("pin_early", {7'h0, irq_oe}, 8'h00);
    repeat (3) @(negedge clock);
  endtask

  // Minute tick, judge pin and flag, then clear the flag
  task automatic fire(input logic [2:0] wd, input logic [5:0] hr, input logic exp);
    tick(wd, hr);
    chk("pin", {6'h0, irq_o, irq_oe}, {7'h0, exp});
    i_host.rd(ADDR_CONTROL2, rv);
    chk("flag", rv, {6'h0, exp, 1'b0});
    i_host.wr(ADDR_CONTROL2, 8'h00);
    chk("pin_clr", {7'h0, irq_oe}, 8'h00);
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset();
    logic [3:0] addr_list [6] = '{ADDR_HOURS, ADDR_ALARM_MINUTE, ADDR_ALARM_HOUR, ADDR_DAY_MASK,
                                  ADDR_CONTROL1, ADDR_CONTROL2};
    chk("reset_pin", {7'h0, irq_oe}, 8'h00);
    foreach (addr_list[i]) begin
      i_host.rd(addr_list[i], rv);
      chk("reset_val", rv, 8'h00);
    end
  endtask

  // Power-on in mid-run wipes settings and a raised flag
  task automatic t_power_on();
    i_host.wr(ADDR_CONTROL1, 8'h80);
    tick(3'h5, 6'h31);
    chk("pin_pre_rst", {7'h0, irq_oe}, 8'h01);
    sys_rst = 1'b1;
    @(negedge clock);
    chk("pin_in_rst", {7'h0, irq_oe}, 8'h00);
    repeat (4) @(negedge clock);
    sys_rst = 1'b0;
    t_reset();
  endtask

  // Format chosen before any time is written
  task automatic t_format();
    i_host.wr(ADDR_HOURS, 8'h80);
    chk("fmt24", {7'h0, hour_format_sel}, 8'h01);
    i_host.rd(ADDR_HOURS, rv);
    chk("fmt_rd", rv, 8'h80);
    i_host.wr(ADDR_HOURS, 8'h00);
    chk("fmt12", {7'h0, hour_format_sel}, 8'h00);
  endtask

  // Alarm Mon/Wed/Fri at 11:59 PM, set up while disabled
  task automatic t_setup();
    i_host.wr(ADDR_CONTROL1, 8'h00);
    i_host.wr(ADDR_DAY_MASK, 8'h2a);
    i_host.wr(ADDR_ALARM_HOUR, 8'h31);
    i_host.wr(ADDR_ALARM_MINUTE, 8'h59);
    i_host.wr(ADDR_CONTROL2, 8'h00);
    fire(3'h1, 6'h31, 1'b0);
    cur_time = {3'h1, 6'h31, 7'h59};
    i_host.wr(ADDR_CONTROL1, 8'h80);
    repeat (2445) @(negedge clock);
    chk("no_setup_fire", {7'h0, irq_oe}, 8'h00);
  endtask

  // Every weekday code; repeats after clearing; PM bit counts
  task automatic t_days();
    for (int d = 0; d < 8; d++)
      fire(3'(d), 6'h31, (d < 7) && (8'h2a >> d) & 1);
    fire(3'h1, 6'h11, 1'b0);
  endtask

  // Write of one ignored, flag sticks, disable stops the alarm
  task automatic t_sticky();
    tick(3'h3, 6'h31);
    i_host.wr(ADDR_CONTROL2, 8'h02);
    repeat (100) @(negedge clock);
    chk("pin_hold", {7'h0, irq_oe}, 8'h01);
    i_host.wr(ADDR_CONTROL1, 8'h00);
    chk("pin_off", {7'h0, irq_oe}, 8'h00);
    fire(3'h3, 6'h31, 1'b0);
  endtask

  // Main sequence after a five-cycle reset
  initial begin
    repeat (5) @(posedge clock);
    @(negedge clock);
    sys_rst = 1'b0;
    t_reset();
    t_format();
    t_setup();
    t_days();
    t_sticky();
    t_power_on();
    end_of_test();
  end

  // Watchdog well beyond the roughly 34k cycles the tests need
  initial begin
    repeat (60000) @(posedge clock);
    fail_count++;
    end_of_test();
  end
endmodule // tb
